// *** hw/apis_irq_status.sv ***
// Contract
// - system alarm flag sits at bit 7 and drives the interrupt pin
// - flags reset to zero, writing one clears, writing zero keeps
// - edge select zero: rising live system alarm sets its flag
// - edge select one: any live alarm transition sets its flag
// - line alarm flag at bit 6 behaves the same as system alarm
// - pattern sync flag at bit 5 set on rising live status, or on any transition with edge select bit 5 one
`timescale 1ns/1ps
`default_nettype none
`include "apis_regs.svh"
module apis_irq_status (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_hsel,
  input  wire logic [7:0]          i_haddr,
  input  wire apis_pkg::apis_htrans_e i_htrans,
  input  wire logic                i_hwrite,
  input  wire logic [2:0]          i_hsize,
  input  wire apis_pkg::apis_word_t i_hwdata,
  input  wire logic                i_hready,
  output logic [31:0]              o_hrdata,
  output logic                     o_hreadyout,
  output logic                     o_hresp,
  input  wire logic                i_sys_alarm_live_status,
  input  wire logic                i_line_alarm_live_status,
  input  wire logic                i_pattern_sync_live_status,
  output logic                     o_irq_n
);
  import apis_pkg::*;

  // -------------------------------------------------------
  // live status synchronisers
  // -------------------------------------------------------
  logic [2:0] live_meta_ff;
  logic [2:0] live_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      live_meta_ff <= 3'h0;
      live_ff      <= 3'h0;
    end else begin
      live_meta_ff <= {i_sys_alarm_live_status, i_line_alarm_live_status, i_pattern_sync_live_status};
      live_ff      <= live_meta_ff;
    end
  end

  // -------------------------------------------------------
  // ahb-lite address phase capture
  // -------------------------------------------------------
  logic       wr_pend_ff;
  logic [7:0] addr_ff;
  logic       take;
  assign take = i_hsel & i_hready & i_htrans[1];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end else begin
      wr_pend_ff <= take & i_hwrite;
      if (take) begin
        addr_ff <= i_haddr;
      end
    end
  end

  // zero wait state, always okay
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // -------------------------------------------------------
  // control registers
  // -------------------------------------------------------
  logic [7:0] edge_sel_ff;
  logic [7:0] mask_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      edge_sel_ff <= `APIS_RST_EDGE_SEL;
      mask_ff     <= `APIS_RST_MASK;
    end else if (wr_pend_ff) begin
      if (addr_ff == `APIS_OFF_EDGE_SEL) begin
        edge_sel_ff <= i_hwdata[7:0];
      end
      if (addr_ff == `APIS_OFF_MASK) begin
        mask_ff <= i_hwdata[7:0];
      end
    end
  end

  // -------------------------------------------------------
  // flag bank
  // -------------------------------------------------------
  apis_flag_if fif ();
  logic       clr_wr;
  assign clr_wr = wr_pend_ff & (addr_ff == `APIS_OFF_STATUS);
  assign fif.live = live_ff;
  // both alarm flags share one select bit
  assign fif.any_edge = {edge_sel_ff[`APIS_BIT_ALARM_ES], edge_sel_ff[`APIS_BIT_ALARM_ES],
                         edge_sel_ff[`APIS_BIT_PATTERN_ES]};
  assign fif.clr = clr_wr ? {i_hwdata[`APIS_BIT_SYS_ALARM], i_hwdata[`APIS_BIT_LINE_ALARM],
                             i_hwdata[`APIS_BIT_PATTERN]} : 3'h0;

  apis_flag_bank u_flags (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .fl    (fif.flags)
  );

  logic [7:0] status;
  assign status = {fif.flag, 5'h00};

  // -------------------------------------------------------
  // read data and interrupt
  // -------------------------------------------------------
  logic [7:0] rd_addr_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_addr_ff <= 8'h00;
    end else if (take) begin
      rd_addr_ff <= i_haddr;
    end
  end

  always_comb begin
    unique case (rd_addr_ff)
      `APIS_OFF_STATUS:   o_hrdata = {24'h000000, status};
      `APIS_OFF_EDGE_SEL: o_hrdata = {24'h000000, edge_sel_ff};
      `APIS_OFF_LIVE:     o_hrdata = {24'h000000, live_ff, 5'h00};
      `APIS_OFF_MASK:     o_hrdata = {24'h000000, mask_ff};
      default:            o_hrdata = 32'h00000000;
    endcase
  end

  logic irq_n_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= ~|(status & mask_ff);
    end
  end
  assign o_irq_n = irq_n_ff;

  // -------------------------------------------------------
  // bus and synchroniser checks
  // -------------------------------------------------------
  ready_high_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_hreadyout)
    else $error("ready dropped");

  resp_okay_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_hresp)
    else $error("error response");

  upper_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_hrdata[31:8] == 24'h000000)
    else $error("upper read bits set");

  read_status_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (rd_addr_ff == `APIS_OFF_STATUS) |-> (o_hrdata[7:0] == status))
    else $error("status read wrong");

  live_sync_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |=> (live_ff == $past(live_meta_ff)))
    else $error("sync stage skipped");

  edge_sel_stable_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_pend_ff |=> $stable(edge_sel_ff))
    else $error("edge select moved");

  mask_stable_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !wr_pend_ff |=> $stable(mask_ff))
    else $error("mask moved");

  // -------------------------------------------------------
  // flag checks, live edges seen after the synchroniser
  // -------------------------------------------------------
  sys_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[6] && $rose(live_ff[2])) |=> status[7])
    else $error("sys rise missed");

  sys_no_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[6] && $fell(live_ff[2]) && !status[7]) |=> !status[7])
    else $error("sys fall set flag");

  sys_any_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (edge_sel_ff[6] && $changed(live_ff[2])) |=> status[7])
    else $error("sys transition missed");

  sys_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[7] && $stable(live_ff[2])) |=> !status[7])
    else $error("sys clear failed");

  keep_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && !i_hwdata[7] && status[7]) |=> status[7])
    else $error("zero write cleared");

  sys_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!clr_wr && status[7]) |=> status[7])
    else $error("sys flag lost");

  sys_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!status[7] && $stable(live_ff[2])) |=> !status[7])
    else $error("sys flag set from nothing");

  sys_set_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[7] && $rose(live_ff[2])) |=> status[7])
    else $error("sys clear beat set");

  line_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[6] && $rose(live_ff[1])) |=> status[6])
    else $error("line rise missed");

  line_no_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[6] && $fell(live_ff[1]) && !status[6]) |=> !status[6])
    else $error("line fall set flag");

  line_any_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (edge_sel_ff[6] && $changed(live_ff[1])) |=> status[6])
    else $error("line transition missed");

  line_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[6] && $stable(live_ff[1])) |=> !status[6])
    else $error("line clear failed");

  line_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && !i_hwdata[6] && status[6]) |=> status[6])
    else $error("line zero write cleared");

  line_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!clr_wr && status[6]) |=> status[6])
    else $error("line flag lost");

  line_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!status[6] && $stable(live_ff[1])) |=> !status[6])
    else $error("line flag set from nothing");

  line_set_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[6] && $rose(live_ff[1])) |=> status[6])
    else $error("line clear beat set");

  pattern_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[5] && $rose(live_ff[0])) |=> status[5])
    else $error("pattern edge missed");

  pat_no_fall_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!edge_sel_ff[5] && $fell(live_ff[0]) && !status[5]) |=> !status[5])
    else $error("pattern fall set flag");

  pat_any_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (edge_sel_ff[5] && $changed(live_ff[0])) |=> status[5])
    else $error("pattern transition missed");

  pat_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[5] && $stable(live_ff[0])) |=> !status[5])
    else $error("pattern clear failed");

  pat_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && !i_hwdata[5] && status[5]) |=> status[5])
    else $error("pattern zero write cleared");

  pat_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!clr_wr && status[5]) |=> status[5])
    else $error("pattern flag lost");

  pat_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!status[5] && $stable(live_ff[0])) |=> !status[5])
    else $error("pattern flag set from nothing");

  pat_set_wins_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (clr_wr && i_hwdata[5] && $rose(live_ff[0])) |=> status[5])
    else $error("pattern clear beat set");

  // -------------------------------------------------------
  // interrupt pin checks
  // -------------------------------------------------------
  irq_follows_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (|(status & mask_ff)) |=> !o_irq_n)
    else $error("irq not asserted");

  irq_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (status == 8'h00) |=> o_irq_n)
    else $error("irq not released");

  masked_quiet_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ((status & mask_ff) == 8'h00) |=> o_irq_n)
    else $error("masked flag drove irq");

  sys_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (status[7] && mask_ff[7]) |=> !o_irq_n)
    else $error("sys alarm not on pin");

  line_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (status[6] && mask_ff[6]) |=> !o_irq_n)
    else $error("line alarm not on pin");

  pat_pin_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (status[5] && mask_ff[5]) |=> !o_irq_n)
    else $error("pattern not on pin");
endmodule
`default_nettype wire

// *** hw/apis_regs.svh ***
`ifndef APIS_REGS_SVH
`define APIS_REGS_SVH
// byte offsets of the register words
`define APIS_OFF_STATUS    8'h00
`define APIS_OFF_EDGE_SEL  8'h04
`define APIS_OFF_LIVE      8'h08
`define APIS_OFF_MASK      8'h0c
// field positions
`define APIS_BIT_SYS_ALARM 7
`define APIS_BIT_LINE_ALARM 6
`define APIS_BIT_PATTERN   5
`define APIS_BIT_ALARM_ES  6
`define APIS_BIT_PATTERN_ES 5
// reset values
`define APIS_RST_STATUS    8'h00
`define APIS_RST_EDGE_SEL  8'h00
`define APIS_RST_MASK      8'he0
`endif

// *** hw/apis_pkg.sv ***
package apis_pkg;
  typedef logic [7:0]  apis_byte_t;
  typedef logic [31:0] apis_word_t;
  typedef enum logic [1:0] {
    APIS_HTRANS_IDLE   = 2'b00,
    APIS_HTRANS_BUSY   = 2'b01,
    APIS_HTRANS_NONSEQ = 2'b10,
    APIS_HTRANS_SEQ    = 2'b11
  } apis_htrans_e;
endpackage

// *** hw/apis_flag_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ties the flag module to its owner
interface apis_flag_if;
  logic [2:0] live;
  logic [2:0] any_edge;
  logic [2:0] clr;
  logic [2:0] flag;
  modport owner (output live, output any_edge, output clr, input flag);
  modport flags (input live, input any_edge, input clr, output flag);
endinterface
`default_nettype wire

// *** hw/apis_flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module apis_flag_bank (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  apis_flag_if.flags  fl
);
  import apis_pkg::*;

  logic [2:0] prev_ff;
  logic [2:0] flag_ff;
  logic [2:0] nxt_flag;
  logic [2:0] hit;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_ff <= 3'h0;
    end else begin
      prev_ff <= fl.live;
    end
  end

  // -------------------------------------------------------
  // edge detect per flag, set beats a same-cycle clear
  // -------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      assign hit[g] = fl.any_edge[g] ? (fl.live[g] ^ prev_ff[g])
                                     : (fl.live[g] & ~prev_ff[g]);
      assign nxt_flag[g] = hit[g] | (flag_ff[g] & ~fl.clr[g]);
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      flag_ff <= 3'h0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end

  assign fl.flag = flag_ff;

  rising_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (!fl.any_edge[2] && fl.live[2] && !prev_ff[2]) |=> flag_ff[2]) else $error("missed rising edge");
  falling_sets_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (fl.any_edge[2] && !fl.live[2] && prev_ff[2]) |=> flag_ff[2]) else $error("missed falling edge");
  clear_works_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (fl.clr[1] && !hit[1]) |=> !flag_ff[1]) else $error("clear failed");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import apis_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hrdy, irq_n, hresp;
  logic sys = 1'b0, line = 1'b0, pat = 1'b0;
  logic [7:0] haddr = 8'h00;
  apis_htrans_e htrans = APIS_HTRANS_IDLE;
  apis_word_t hwdata = 32'h0, hrdata, q;
  int fails = 0, samples_checked = 0, cycles = 0;

  always #50 i_clk = ~i_clk;

  apis_irq_status apis_irq_status_inst (
    .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .i_sys_alarm_live_status(sys),
    .i_line_alarm_live_status(line), .i_pattern_sync_live_status(pat), .o_irq_n(irq_n));

  // ----------------------------------------
  // bus cycles and comparisons
  // ----------------------------------------
  // entered at a rising edge; returns at the edge that takes the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input apis_word_t d);
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= APIS_HTRANS_NONSEQ;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= APIS_HTRANS_IDLE; hwdata <= d;
    do @(posedge i_clk); while (hrdy !== 1'b1);
    q = hrdata;
  endtask

  task automatic chk(input apis_word_t got, input apis_word_t exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input apis_word_t exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // live inputs pass a two-stage synchroniser before the flag and the pin react
  task automatic settle();
    repeat (6) @(posedge i_clk);
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // a hung handshake ends here instead of running forever
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdc(8'h00, 32'h00);
    rdc(8'h04, 32'h00);
    rdc(8'h0c, 32'he0);
    chk({31'h0, irq_n}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hrdy}, 32'h1);
    $display("test reset values done");
    sys <= 1'b1;
    settle();
    chk({31'h0, irq_n}, 32'h0);
    rdc(8'h00, 32'h80);
    rdc(8'h08, 32'h80);
    xfer(1'b1, 8'h00, 32'h7f);
    rdc(8'h00, 32'h80);
    xfer(1'b1, 8'h00, 32'h80);
    rdc(8'h00, 32'h00);
    chk({31'h0, irq_n}, 32'h1);
    sys <= 1'b0;
    settle();
    rdc(8'h00, 32'h00);
    $display("test system alarm rising edge done");
    line <= 1'b1;
    settle();
    rdc(8'h00, 32'h40);
    xfer(1'b1, 8'h0c, 32'h00);
    settle();
    chk({31'h0, irq_n}, 32'h1);
    xfer(1'b1, 8'h0c, 32'he0);
    settle();
    chk({31'h0, irq_n}, 32'h0);
    xfer(1'b1, 8'h00, 32'h40);
    pat <= 1'b1;
    settle();
    rdc(8'h00, 32'h20);
    xfer(1'b1, 8'h00, 32'h20);
    rdc(8'h00, 32'h00);
    $display("test line alarm, mask and pattern done");
    xfer(1'b1, 8'h04, 32'h40);
    rdc(8'h04, 32'h40);
    sys <= 1'b1;
    line <= 1'b0;
    settle();
    xfer(1'b1, 8'h00, 32'he0);
    sys <= 1'b0;
    settle();
    rdc(8'h00, 32'h80);
    line <= 1'b1;
    settle();
    rdc(8'h00, 32'hc0);
    xfer(1'b1, 8'h00, 32'hc0);
    settle();
    chk({31'h0, irq_n}, 32'h1);
    xfer(1'b1, 8'h04, 32'h20);
    pat <= 1'b0;
    settle();
    rdc(8'h00, 32'h20);
    chk({31'h0, irq_n}, 32'h0);
    xfer(1'b1, 8'h00, 32'h20);
    rdc(8'h00, 32'h00);
    $display("test any-edge select done");
    xfer(1'b1, 8'h10, 32'hff);
    rdc(8'h10, 32'h00);
    rdc(8'h00, 32'h00);
    $display("test unmapped address done");
    report_and_stop();
  end
endmodule
`default_nettype wire
